// >>> oad_consts.svh
// Field positions, encodings and reset values of the operand address decoder.
`ifndef OAD_CONSTS_SVH
`define OAD_CONSTS_SVH
`define OAD_FORM_MSB 7
`define OAD_FORM_LSB 6
`define OAD_REG_MSB 5
`define OAD_REG_LSB 3
`define OAD_SEL_MSB 2
`define OAD_SEL_LSB 0
`define OAD_FORM_NODISP 2'h0
`define OAD_FORM_DISP8 2'h1
`define OAD_FORM_DISP16 2'h2
`define OAD_FORM_REG 2'h3
`define OAD_SEL_DIRECT 3'h6
`define OAD_SEG_EXTRA 2'h0
`define OAD_SEG_CODE 2'h1
`define OAD_SEG_STACK 2'h2
`define OAD_SEG_DATA 2'h3
`define OAD_WORD_RESET 16'h0000
`endif

// >>> oad_pkg.sv
// Types shared by the operand address decoder files.
`default_nettype none
package oad_pkg;
  typedef enum logic [3:0] {
    GR_ACCUM, GR_COUNT, GR_DATA, GR_BASE, GR_STACK_PTR, GR_BASE_PTR, GR_SRC_IDX, GR_DST_IDX
  } word_reg_t;
  typedef enum logic [3:0] {
    BR_ACCUM_LOW, BR_COUNT_LOW, BR_DATA_LOW, BR_BASE_LOW_BYTE,
    BR_ACCUM_HIGH_BYTE, BR_COUNT_HIGH_BYTE, BR_DATA_HIGH_BYTE, BR_BASE_HIGH_BYTE
  } byte_reg_t;
  typedef enum logic [1:0] {
    SEG_EXTRA_SEGMENT, SEG_CODE, SEG_STACK, SEG_DATA_SEGMENT
  } seg_reg_t;
  typedef enum logic [2:0] {
    ST_MODRM, ST_DISP_LOW, ST_DISP_HIGH, ST_DONE
  } dec_state_t;
endpackage : oad_pkg
`default_nettype wire

// >>> oad_reg_map.sv
// Register code tables for word, byte and segment operands.
`timescale 1ns/1ps
`default_nettype none
`include "oad_consts.svh"
module oad_reg_map
  import oad_pkg::*;
(
  input wire logic [2:0] regCode,
  input wire logic [1:0] segCode,
  input wire logic wordOp,
  output logic [3:0] regIndex,
  output logic regIsByte,
  output seg_reg_t segSel
);
  // Word and byte tables share the code order, so the index is the code itself.
  always_comb begin
    regIsByte = !wordOp;
    if (wordOp) begin
      regIndex = 4'(word_reg_t'(4'(regCode)));
    end else begin
      regIndex = 4'(byte_reg_t'(4'(regCode)));
    end
  end

  always_comb begin
    case (segCode)
      `OAD_SEG_EXTRA: segSel = SEG_EXTRA_SEGMENT;
      `OAD_SEG_CODE: segSel = SEG_CODE;
      `OAD_SEG_STACK: segSel = SEG_STACK;
      `OAD_SEG_DATA: segSel = SEG_DATA_SEGMENT;
      default: segSel = SEG_EXTRA_SEGMENT;
    endcase
  end
endmodule : oad_reg_map
`default_nettype wire

// >>> operand_address_decoder.sv
// Operand addressing byte decoder with displacement fetch and address adder.
//
// Contract
// - Form 10 builds a 16-bit offset, high byte above low byte.
// - Selector 000 adds base and source index; 001 base and destination index.
// - Selector 010 adds base pointer and source index; 011 with destination index.
// - Selector 100 uses source index; 101 destination index, each plus offset.
// - Selector 110 uses base pointer plus offset; 111 base register plus offset.
// - Offset bytes follow the second instruction byte; immediate data comes after.
// - Word register codes 011 to 111 map base, stack, base pointer, indexes.
// - Byte codes 011 to 111 map base low, accum, count, data, base high.
// - Segment code 00 selects extra segment, 11 selects data segment.
// - Form 00 has zero offset and fetches none, except direct address.
// - Form 01 fetches one offset byte and sign-extends it.
// - Form 11 treats the selector as a register code.
// - Width bit 1 picks word registers, 0 picks byte registers.
`timescale 1ns/1ps
`default_nettype none
`include "oad_consts.svh"
module operand_address_decoder
  import oad_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic modrmValid,
  input wire logic [7:0] modrmByte,
  input wire logic wordOp,
  input wire logic [1:0] segCode,
  input wire logic byteValid,
  input wire logic [7:0] streamByte,
  output logic byteReady,
  input wire logic [WIDTH-1:0] baseRegister,
  input wire logic [WIDTH-1:0] basePointer,
  input wire logic [WIDTH-1:0] sourceIndex,
  input wire logic [WIDTH-1:0] destinationIndex,
  output logic busy,
  output logic done,
  output logic memOperand,
  output logic [WIDTH-1:0] effectiveAddress,
  output logic [WIDTH-1:0] offsetConstant,
  output logic [3:0] rmRegIndex,
  output logic rmIsByte,
  output logic [3:0] regFieldIndex,
  output logic regFieldIsByte,
  output seg_reg_t segSel
);
  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers.
  function automatic logic [WIDTH-1:0] addr_sum(input logic [2:0] sel,
      input logic [WIDTH-1:0] disp);
    logic [WIDTH-1:0] a;
    logic [WIDTH-1:0] b;
    a = '0;
    b = '0;
    case (sel)
      3'h0: begin a = baseRegister; b = sourceIndex; end
      3'h1: begin a = baseRegister; b = destinationIndex; end
      3'h2: begin a = basePointer; b = sourceIndex; end
      3'h3: begin a = basePointer; b = destinationIndex; end
      3'h4: begin a = sourceIndex; end
      3'h5: begin a = destinationIndex; end
      3'h6: begin a = basePointer; end
      3'h7: begin a = baseRegister; end
      default: begin a = '0; end
    endcase
    // Carries beyond the top bit are dropped on purpose.
    addr_sum = WIDTH'(a + b + disp);
  endfunction : addr_sum

  function automatic logic is_direct(input logic [1:0] form, input logic [2:0] sel);
    is_direct = (form == `OAD_FORM_NODISP) && (sel == `OAD_SEL_DIRECT);
  endfunction : is_direct

  ////////////////////////////////////////////////////////////////////////////////
  // Fetch sequence.
  dec_state_t state_r, state_nxt;
  logic [1:0] form_r, form_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic [2:0] regf_r, regf_nxt;
  logic word_r, word_nxt;
  logic [1:0] seg_r, seg_nxt;
  logic [7:0] dispLow_r, dispLow_nxt;
  logic [WIDTH-1:0] offset_r, offset_nxt;
  logic [WIDTH-1:0] ea_r, ea_nxt;
  logic done_r, done_nxt;
  logic mem_r, mem_nxt;

  assign byteReady = (state_r == ST_DISP_LOW) || (state_r == ST_DISP_HIGH);

  always_comb begin
    state_nxt = state_r;
    form_nxt = form_r;
    sel_nxt = sel_r;
    regf_nxt = regf_r;
    word_nxt = word_r;
    seg_nxt = seg_r;
    dispLow_nxt = dispLow_r;
    offset_nxt = offset_r;
    ea_nxt = ea_r;
    mem_nxt = mem_r;
    done_nxt = 1'b0;
    case (state_r)
      ST_MODRM, ST_DONE: begin
        state_nxt = ST_MODRM;
        if (modrmValid) begin
          form_nxt = modrmByte[`OAD_FORM_MSB:`OAD_FORM_LSB];
          sel_nxt = modrmByte[`OAD_SEL_MSB:`OAD_SEL_LSB];
          regf_nxt = modrmByte[`OAD_REG_MSB:`OAD_REG_LSB];
          word_nxt = wordOp;
          seg_nxt = segCode;
          mem_nxt = (modrmByte[`OAD_FORM_MSB:`OAD_FORM_LSB] != `OAD_FORM_REG);
          if ((modrmByte[`OAD_FORM_MSB:`OAD_FORM_LSB] == `OAD_FORM_NODISP) &&
              !is_direct(modrmByte[`OAD_FORM_MSB:`OAD_FORM_LSB],
                         modrmByte[`OAD_SEL_MSB:`OAD_SEL_LSB])) begin
            offset_nxt = `OAD_WORD_RESET;
            ea_nxt = addr_sum(modrmByte[`OAD_SEL_MSB:`OAD_SEL_LSB], `OAD_WORD_RESET);
            state_nxt = ST_DONE;
            done_nxt = 1'b1;
          end else if (modrmByte[`OAD_FORM_MSB:`OAD_FORM_LSB] == `OAD_FORM_REG) begin
            offset_nxt = `OAD_WORD_RESET;
            ea_nxt = `OAD_WORD_RESET;
            state_nxt = ST_DONE;
            done_nxt = 1'b1;
          end else begin
            state_nxt = ST_DISP_LOW;
          end
        end
      end
      ST_DISP_LOW: begin
        if (byteValid) begin
          dispLow_nxt = streamByte;
          if (form_r == `OAD_FORM_DISP8) begin
            offset_nxt = {{(WIDTH-8){streamByte[7]}}, streamByte};
            ea_nxt = addr_sum(sel_r, {{(WIDTH-8){streamByte[7]}}, streamByte});
            state_nxt = ST_DONE;
            done_nxt = 1'b1;
          end else begin
            state_nxt = ST_DISP_HIGH;
          end
        end
      end
      ST_DISP_HIGH: begin
        if (byteValid) begin
          offset_nxt = WIDTH'({streamByte, dispLow_r});
          if (is_direct(form_r, sel_r)) begin
            ea_nxt = WIDTH'({streamByte, dispLow_r});
          end else begin
            ea_nxt = addr_sum(sel_r, WIDTH'({streamByte, dispLow_r}));
          end
          state_nxt = ST_DONE;
          done_nxt = 1'b1;
        end
      end
      default: state_nxt = ST_MODRM;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_MODRM;
      form_r <= 2'h0;
      sel_r <= 3'h0;
      regf_r <= 3'h0;
      word_r <= 1'b0;
      seg_r <= 2'h0;
      dispLow_r <= 8'h00;
      offset_r <= `OAD_WORD_RESET;
      ea_r <= `OAD_WORD_RESET;
      done_r <= 1'b0;
      mem_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      form_r <= form_nxt;
      sel_r <= sel_nxt;
      regf_r <= regf_nxt;
      word_r <= word_nxt;
      seg_r <= seg_nxt;
      dispLow_r <= dispLow_nxt;
      offset_r <= offset_nxt;
      ea_r <= ea_nxt;
      done_r <= done_nxt;
      mem_r <= mem_nxt;
    end
  end

  assign busy = (state_r == ST_DISP_LOW) || (state_r == ST_DISP_HIGH);
  assign done = done_r;
  assign memOperand = mem_r;
  assign effectiveAddress = ea_r;
  assign offsetConstant = offset_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Register selection from the latched fields.
  logic [3:0] rmIdx;
  logic rmByte;

  oad_reg_map rmMap (
    .regCode(sel_r),
    .segCode(seg_r),
    .wordOp(word_r),
    .regIndex(rmIdx),
    .regIsByte(rmByte),
    .segSel()
  );

  oad_reg_map regMap (
    .regCode(regf_r),
    .segCode(seg_r),
    .wordOp(word_r),
    .regIndex(regFieldIndex),
    .regIsByte(regFieldIsByte),
    .segSel(segSel)
  );

  // A memory form has no register operand in the selector field, so its index reads zero.
  assign rmRegIndex = mem_r ? 4'h0 : rmIdx;
  assign rmIsByte = rmByte;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  done_no_disp_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r != ST_DISP_LOW && state_r != ST_DISP_HIGH && modrmValid &&
     modrmByte[7:6] == 2'h0 && modrmByte[2:0] != 3'h6) |=> (done && offsetConstant == 16'h0000))
    else $error("No-offset form did not finish with zero offset.");
  disp8_sign_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_DISP_LOW && byteValid && form_r == 2'h1)
      |=> (done && offsetConstant == {{8{$past(streamByte[7])}}, $past(streamByte)}))
    else $error("Short offset not sign-extended.");
  disp16_order_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_DISP_HIGH && byteValid)
      |=> (offsetConstant == {$past(streamByte), $past(dispLow_r)}))
    else $error("Long offset bytes placed in wrong order.");
  direct_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r == ST_DISP_HIGH && byteValid && form_r == 2'h0) |=> (effectiveAddress == offsetConstant))
    else $error("Direct address not equal to offset.");
  reg_form_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r != ST_DISP_LOW && state_r != ST_DISP_HIGH && modrmValid && modrmByte[7:6] == 2'h3)
      |=> (done && !memOperand && rmRegIndex == {1'b0, $past(modrmByte[2:0])}))
    else $error("Register form not decoded as register.");
  fetch_ready_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r != ST_DISP_LOW && state_r != ST_DISP_HIGH && modrmValid && modrmByte[7:6] == 2'h2)
      |=> (byteReady and (byteValid |=> byteReady)))
    else $error("Long offset did not request two bytes.");
  ea_sum_a: assert property (@(posedge sys_clk) disable iff (rst)
    (done && memOperand && sel_r == 3'h0) |-> effectiveAddress ==
      16'($past(baseRegister) + $past(sourceIndex) + offsetConstant))
    else $error("Base plus source index sum wrong.");
  width_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r != ST_DISP_LOW && state_r != ST_DISP_HIGH && modrmValid)
      |=> (rmIsByte == !$past(wordOp) && regFieldIsByte == !$past(wordOp)))
    else $error("Width bit did not select register table.");
  seg_map_a: assert property (@(posedge sys_clk) disable iff (rst)
    (state_r != ST_DISP_LOW && state_r != ST_DISP_HIGH && modrmValid &&
     segCode inside {2'h0, 2'h3})
      |=> (segSel == (($past(segCode) == 2'h3) ? SEG_DATA_SEGMENT : SEG_EXTRA_SEGMENT)))
    else $error("Segment code 00 or 11 did not pick its segment.");
endmodule : operand_address_decoder
`default_nettype wire

// >>> tb_operand_address_decoder.sv
// Self-checking random testbench of the operand address decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_operand_address_decoder;
  import oad_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic modrmValid = 1'b0;
  logic [7:0] modrmByte = 8'h00;
  logic wordOp = 1'b0;
  logic [1:0] segCode = 2'h0;
  logic byteValid = 1'b0;
  logic [7:0] streamByte = 8'h00;
  logic [15:0] baseRegister = 16'h0000;
  logic [15:0] basePointer = 16'h0000;
  logic [15:0] sourceIndex = 16'h0000;
  logic [15:0] destinationIndex = 16'h0000;
  logic byteReady, busy, done, memOperand, rmIsByte, regFieldIsByte;
  logic [15:0] effectiveAddress, offsetConstant;
  logic [3:0] rmRegIndex, regFieldIndex;
  seg_reg_t segSel;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 97633;

  always #5 sys_clk = ~sys_clk;

  operand_address_decoder #(.WIDTH(16)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .modrmValid(modrmValid), .modrmByte(modrmByte),
    .wordOp(wordOp), .segCode(segCode), .byteValid(byteValid), .streamByte(streamByte),
    .byteReady(byteReady), .baseRegister(baseRegister), .basePointer(basePointer),
    .sourceIndex(sourceIndex), .destinationIndex(destinationIndex), .busy(busy),
    .done(done), .memOperand(memOperand), .effectiveAddress(effectiveAddress),
    .offsetConstant(offsetConstant), .rmRegIndex(rmRegIndex), .rmIsByte(rmIsByte),
    .regFieldIndex(regFieldIndex), .regFieldIsByte(regFieldIsByte), .segSel(segSel)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  function automatic int nbytes(input logic [1:0] f, input logic [2:0] sel);
    case (f)
      2'h0: return (sel == 3'h6) ? 2 : 0;
      2'h1: return 1;
      2'h2: return 2;
      default: return 0;
    endcase
  endfunction : nbytes

  function automatic logic [15:0] offs(input logic [1:0] f, input logic [2:0] sel,
                                       input logic [15:0] d);
    case (f)
      2'h0: return (sel == 3'h6) ? d : 16'h0000;
      2'h1: return {{8{d[7]}}, d[7:0]};
      2'h2: return d;
      default: return 16'h0000;
    endcase
  endfunction : offs

  // The sums are truncated to 16 bits on purpose, so any carry is dropped.
  function automatic logic [15:0] addr(input logic [1:0] f, input logic [2:0] sel,
                                       input logic [15:0] o);
    if (f == 2'h3) return 16'h0000;
    if (f == 2'h0 && sel == 3'h6) return o;
    case (sel)
      3'h0: return 16'(baseRegister + sourceIndex + o);
      3'h1: return 16'(baseRegister + destinationIndex + o);
      3'h2: return 16'(basePointer + sourceIndex + o);
      3'h3: return 16'(basePointer + destinationIndex + o);
      3'h4: return 16'(sourceIndex + o);
      3'h5: return 16'(destinationIndex + o);
      3'h6: return 16'(basePointer + o);
      default: return 16'(baseRegister + o);
    endcase
  endfunction : addr

  // Register tables spelled out by name, so the decoder's code order is not taken on trust.
  function automatic logic [3:0] regmap(input logic [2:0] c, input logic w);
    word_reg_t wr;
    byte_reg_t br;
    wr = GR_ACCUM;
    br = BR_ACCUM_LOW;
    case (c)
      3'h1: begin wr = GR_COUNT; br = BR_COUNT_LOW; end
      3'h2: begin wr = GR_DATA; br = BR_DATA_LOW; end
      3'h3: begin wr = GR_BASE; br = BR_BASE_LOW_BYTE; end
      3'h4: begin wr = GR_STACK_PTR; br = BR_ACCUM_HIGH_BYTE; end
      3'h5: begin wr = GR_BASE_PTR; br = BR_COUNT_HIGH_BYTE; end
      3'h6: begin wr = GR_SRC_IDX; br = BR_DATA_HIGH_BYTE; end
      3'h7: begin wr = GR_DST_IDX; br = BR_BASE_HIGH_BYTE; end
      default: ;
    endcase
    return w ? 4'(wr) : 4'(br);
  endfunction : regmap

  function automatic logic [1:0] segmap(input logic [1:0] s);
    case (s)
      2'h0: return 2'(SEG_EXTRA_SEGMENT);
      2'h1: return 2'(SEG_CODE);
      2'h2: return 2'(SEG_STACK);
      default: return 2'(SEG_DATA_SEGMENT);
    endcase
  endfunction : segmap

  ////////////////////////////////////////////////////////////////////////////////
  // Stall cycles while busy randomly offer a fresh addressing byte that must be refused.
  task automatic decode(input logic [7:0] m, input logic w, input logic [1:0] s,
                        input logic [15:0] d, input logic ones);
    logic [1:0] f;
    logic [2:0] sel;
    logic pres;
    logic [15:0] off;
    int n;
    f = m[7:6];
    sel = m[2:0];
    n = 0;
    modrmValid = 1'b1;
    modrmByte = m;
    wordOp = w;
    segCode = s;
    baseRegister = ones ? 16'hffff : 16'($random(seed));
    basePointer = ones ? 16'hffff : 16'($random(seed));
    sourceIndex = ones ? 16'hffff : 16'($random(seed));
    destinationIndex = ones ? 16'hffff : 16'($random(seed));
    @(posedge sys_clk);
    #1;
    for (int i = 0; i < 40 && done !== 1'b1; i++) begin
      pres = (byteReady === 1'b1) && ($random(seed) % 3 != 0);
      byteValid = pres;
      streamByte = pres ? ((n == 0) ? d[7:0] : d[15:8]) : 8'($random(seed));
      modrmValid = !pres && (busy === 1'b1) && (($random(seed) & 1) != 0);
      if (modrmValid) modrmByte = 8'($random(seed));
      n += int'(pres);
      @(posedge sys_clk);
      #1;
    end
    off = offs(f, sel, d);
    chk(16'(done), 16'h0001);
    chk(16'(n), 16'(nbytes(f, sel)));
    chk(16'(byteReady), 16'h0000);
    if (f != 2'h3) chk(offsetConstant, off);
    chk(effectiveAddress, addr(f, sel, off));
    chk(16'(memOperand), 16'(f != 2'h3));
    chk(16'(rmRegIndex), (f == 2'h3) ? 16'(regmap(sel, w)) : 16'h0000);
    chk(16'({rmIsByte, regFieldIsByte}), {14'h0000, !w, !w});
    chk(16'(regFieldIndex), 16'(regmap(m[5:3], w)));
    chk(16'(segSel), 16'(segmap(s)));
  endtask : decode

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk({14'h0000, done, busy}, 16'h0000);
    chk(effectiveAddress, 16'h0000);
    for (int k = 0; k < 8; k++) decode({2'h2, 3'(k), 3'(k)}, k[0], 2'(k), 16'($random(seed)), 1'b0);
    for (int k = 0; k < 8; k++) decode({2'h0, 3'(k), 3'(k)}, k[1], 2'(k), 16'($random(seed)), 1'b0);
    decode({2'h1, 3'h1, 3'h2}, 1'b1, 2'h0, 16'h5580, 1'b0);
    decode({2'h1, 3'h4, 3'h7}, 1'b0, 2'h3, 16'haa7f, 1'b0);
    for (int k = 0; k < 16; k++) decode({2'h3, 3'(k), 3'(7 - k)}, k[3], 2'(k), 16'h0000, 1'b0);
    decode({2'h2, 3'h0, 3'h0}, 1'b1, 2'h3, 16'hffff, 1'b1);
    decode({2'h1, 3'h0, 3'h3}, 1'b1, 2'h3, 16'h00ff, 1'b1);
    for (int k = 0; k < 200; k++) begin
      decode(8'($random(seed)), 1'($random(seed)), 2'($random(seed)), 16'($random(seed)), 1'b0);
    end
    // A reset in the middle of a long-offset fetch must abandon it and clear the outputs.
    modrmValid = 1'b1;
    modrmByte = 8'h80;
    byteValid = 1'b0;
    @(posedge sys_clk);
    #1;
    chk(16'(busy), 16'h0001);
    modrmValid = 1'b0;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    chk({13'h0000, done, busy, memOperand}, 16'h0000);
    chk(offsetConstant, 16'h0000);
    chk(effectiveAddress, 16'h0000);
    decode(8'h80, 1'b1, 2'h3, 16'h1234, 1'b0);
    modrmValid = 1'b0;
    repeat (3) @(posedge sys_clk);
    conclude();
  end
endmodule : tb_operand_address_decoder
`default_nettype wire
